// *** rtl/tsp_i2c_port.sv ***
// What this block does
// - Write is address+write, pointer, high byte, low byte, each byte acknowledged.
// - With error checking on, a trailing check byte is taken and acknowledged.
// - Read uses repeated start, address+read; high byte then low byte driven.
// - With error checking on, device sends a check byte after the second data byte.
// - Only the device's own strapped address 1001xxx is answered.
// - Configuration and thresholds are read/write; temperature result is read-only.
// - The pointer never advances during reads or writes.
// - Pointer 01h selects the configuration register.
// - Pointers 02h and 03h select the two threshold registers.
// - A lone written data byte lands in bits 15:8.
// - Extra written bytes keep going to the same register.
// - Extra read bytes keep coming from the same register.
// - Temperature is 16-bit two's complement, upper byte first, MSB first.
// - Temperature occupies bits 15:4 (15:3 in extended format); bits below resolution read as zero.
// - Step is 1 degree at 8-bit and 0.0625 degree at 12-bit resolution.
// - Configuration bit 7 selects extended format, doubling the upper weights.
// - With timeout enabled, SCL low for about 30 ms resets the interface.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_params.svh"

module tsp_i2c_port
	import tsp_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = `TSP_TIMEOUT_CYC
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic [2:0]  i_addr_sel,
	input  wire logic [15:0] i_temp_raw,
	input  wire logic        i_temp_valid,
	output logic             o_sda_oe,
	output logic             o_sda_out,
	output logic [15:0]      o_config,
	output logic [15:0]      o_overtemp,
	output logic [15:0]      o_hyst
);

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `TSP_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// Extended format shifts every weight down one bit, so its masks keep one more low bit.
	function automatic logic [15:0] res_mask(input logic ext, input logic [1:0] res);
		case ({ext, res})
			3'b000:  return 16'hff00;
			3'b001:  return 16'hff80;
			3'b010:  return 16'hffc0;
			3'b011:  return 16'hfff0;
			3'b100:  return 16'hff80;
			3'b101:  return 16'hffc0;
			3'b110:  return 16'hffe0;
			default: return 16'hfff8;
		endcase
	endfunction

	tsp_bus_t   s1_q, s2_q, s3_q;
	tsp_state_t state_q;
	logic [2:0]  addr_sel_q;
	logic [2:0]  bitcnt_q;
	logic [7:0]  shift_q;
	logic        rd_q;
	logic [1:0]  wcnt_q;
	logic [7:0]  ptr_q;
	logic [7:0]  hi_q;
	logic [7:0]  crc_q;
	logic [1:0]  rcnt_q;
	logic        ack_q;
	logic        sda_oe_q, sda_out_q;
	logic [15:0] temp_q, config_q, overtemp_q, hyst_q;
	logic [31:0] tmo_q;

	wire scl_rise  = s2_q.scl & ~s3_q.scl;
	wire scl_fall  = ~s2_q.scl & s3_q.scl;
	wire start_det = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
	wire stop_det  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
	wire tmo_hit   = ~config_q[`TSP_CFG_TIMEOUT] && (tmo_q >= TIMEOUT_CYC);
	wire [7:0] byte_in = {shift_q[6:0], s2_q.sda};
	wire pec_on    = config_q[`TSP_CFG_PEC];

	// Two-flop synchroniser; the third stage only feeds edge detection.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_q <= '{scl: 1'b1, sda: 1'b1};
			s2_q <= '{scl: 1'b1, sda: 1'b1};
			s3_q <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			s1_q <= '{scl: i_scl, sda: i_sda};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// The address straps are sampled after reset release, never inside the reset branch.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_sel_q <= 3'h0;
		end else if (state_q == ST_IDLE) begin
			addr_sel_q <= i_addr_sel;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tmo_q <= 32'h0;
		end else if (s2_q.scl || state_q == ST_IDLE) begin
			tmo_q <= 32'h0;
		end else if (!tmo_hit) begin
			tmo_q <= tmo_q + 32'h1;
		end
	end

	// Readback picks the register by the pointer alone, so repeated reads repeat it.
	function automatic logic [15:0] sel_reg(input logic [7:0] p);
		if (p == `TSP_PTR_CONFIG) begin
			return config_q;
		end else if (p == `TSP_PTR_HYST) begin
			return hyst_q;
		end else if (p == `TSP_PTR_OVERTEMP) begin
			return overtemp_q;
		end else begin
			return temp_q;
		end
	endfunction

	logic [15:0] rd_word;
	logic [7:0]  tx_byte;
	always_comb begin
		rd_word = sel_reg(ptr_q);
		if (rcnt_q == 2'd2 && pec_on) begin
			tx_byte = crc_q;
		end else if (rcnt_q[0]) begin
			tx_byte = rd_word[7:0];
		end else begin
			tx_byte = rd_word[15:8];
		end
	end

	// Bit engine: samples on SCL rise, changes SDA after SCL fall.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q   <= ST_IDLE;
			bitcnt_q  <= 3'h0;
			shift_q   <= 8'h00;
			rd_q      <= 1'b0;
			wcnt_q    <= 2'h0;
			ptr_q     <= `TSP_PTR_TEMP;
			hi_q      <= 8'h00;
			crc_q     <= 8'h00;
			rcnt_q    <= 2'h0;
			ack_q     <= 1'b0;
			sda_oe_q  <= 1'b0;
			sda_out_q <= 1'b0;
		end else if (stop_det || tmo_hit) begin
			state_q  <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			state_q  <= ST_ADDR;
			bitcnt_q <= 3'h0;
			sda_oe_q <= 1'b0;
			if (state_q == ST_IDLE) begin
				crc_q  <= 8'h00;
				wcnt_q <= 2'h0;
			end
		end else begin
			case (state_q)
				ST_ADDR: begin
					if (scl_rise) begin
						shift_q  <= byte_in;
						bitcnt_q <= bitcnt_q + 3'h1;
						if (bitcnt_q == 3'h7) begin
							state_q <= ST_ADDR_ACK;
							rd_q    <= s2_q.sda;
							ack_q   <= (byte_in[7:1] == {`TSP_ADDR_BASE, addr_sel_q});
							crc_q   <= crc8_step(crc_q, byte_in);
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (!ack_q) begin
							state_q  <= ST_IDLE;
							sda_oe_q <= 1'b0;
						end else if (!sda_oe_q) begin
							sda_oe_q  <= 1'b1;
							sda_out_q <= 1'b0;
						end else if (rd_q) begin
							state_q   <= ST_READ;
							rcnt_q    <= 2'h0;
							sda_out_q <= rd_word[15];
							shift_q   <= {rd_word[14:8], 1'b0};
							bitcnt_q  <= 3'h1;
						end else begin
							state_q  <= ST_WRITE;
							sda_oe_q <= 1'b0;
							bitcnt_q <= 3'h0;
						end
					end
				end
				ST_WRITE: begin
					if (scl_rise) begin
						shift_q  <= byte_in;
						bitcnt_q <= bitcnt_q + 3'h1;
						if (bitcnt_q == 3'h7) begin
							state_q <= ST_WRITE_ACK;
							crc_q   <= crc8_step(crc_q, byte_in);
							if (wcnt_q == 2'h0) begin
								ptr_q <= byte_in;
							end else if (wcnt_q[0]) begin
								hi_q <= byte_in;
							end
							if (wcnt_q == 2'h3) begin
								wcnt_q <= 2'h2;
							end else begin
								wcnt_q <= wcnt_q + 2'h1;
							end
						end
					end
				end
				ST_WRITE_ACK: begin
					if (scl_fall) begin
						if (!sda_oe_q) begin
							sda_oe_q  <= 1'b1;
							sda_out_q <= 1'b0;
						end else begin
							state_q  <= ST_WRITE;
							sda_oe_q <= 1'b0;
							bitcnt_q <= 3'h0;
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (bitcnt_q == 3'h0) begin
							state_q  <= ST_READ_ACK;
							sda_oe_q <= 1'b0;
							crc_q    <= crc8_step(crc_q, tx_byte);
						end else begin
							sda_out_q <= shift_q[7];
							shift_q   <= {shift_q[6:0], 1'b0};
							bitcnt_q  <= bitcnt_q + 3'h1;
						end
					end
				end
				ST_READ_ACK: begin
					if (scl_rise && s2_q.sda) begin
						state_q <= ST_IDLE;
					end else if (scl_fall) begin
						state_q   <= ST_READ;
						rcnt_q    <= (rcnt_q == 2'h2 || (rcnt_q == 2'h1 && !pec_on)) ? 2'h0 : rcnt_q + 2'h1;
						sda_oe_q  <= 1'b1;
						sda_out_q <= next_tx[7];
						shift_q   <= {next_tx[6:0], 1'b0};
						bitcnt_q  <= 3'h1;
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// The first read data bit must come from the byte about to be sent, which differs after an ack.
	logic [7:0] next_tx;
	always_comb begin
		if (rcnt_q == 2'h1 && pec_on) begin
			next_tx = crc_q;
		end else if (rcnt_q == 2'h0) begin
			next_tx = rd_word[7:0];
		end else begin
			next_tx = rd_word[15:8];
		end
	end

	logic load_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			load_q <= 1'b0;
		end else begin
			load_q <= (state_q == ST_READ_ACK) && scl_fall && !stop_det && !start_det && !tmo_hit;
		end
	end

	logic [7:0] drive_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			drive_q <= 8'h00;
		end else if (state_q == ST_READ_ACK && scl_fall) begin
			drive_q <= next_tx;
		end
	end

	// Register writes take effect when a high byte completes and again when its low byte completes.
	// With error checking on, the byte after the low byte is the check byte; it is not written but is kept as the next high byte.
	wire wr_low  = (state_q == ST_WRITE) && scl_rise && (bitcnt_q == 3'h7) && (wcnt_q == 2'h2);
	wire wr_high = (state_q == ST_WRITE) && scl_rise && (bitcnt_q == 3'h7) && wcnt_q[0];
	wire wr_pec  = wr_high && pec_on && (wcnt_q == 2'h3);
	wire wr_en   = wr_low || wr_high;
	wire [15:0] wr_word = wr_low ? {hi_q, byte_in} : {byte_in, rd_word[7:0]};

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			config_q   <= `TSP_RST_CONFIG;
			hyst_q     <= `TSP_RST_HYST;
			overtemp_q <= `TSP_RST_OVERTEMP;
		end else if (wr_en && !wr_pec) begin
			if (ptr_q == `TSP_PTR_CONFIG) begin
				config_q <= wr_word;
			end else if (ptr_q == `TSP_PTR_HYST) begin
				hyst_q <= wr_word;
			end else if (ptr_q == `TSP_PTR_OVERTEMP) begin
				overtemp_q <= wr_word;
			end
		end
	end

	// The result register has no write path at all.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			temp_q <= `TSP_RST_TEMP;
		end else if (i_temp_valid) begin
			temp_q <= i_temp_raw & res_mask(config_q[`TSP_CFG_FORMAT], config_q[`TSP_CFG_RES_HI:`TSP_CFG_RES_LO]);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sda_oe  <= 1'b0;
			o_sda_out <= 1'b0;
			o_config  <= `TSP_RST_CONFIG;
			o_overtemp <= `TSP_RST_OVERTEMP;
			o_hyst    <= `TSP_RST_HYST;
		end else begin
			o_sda_oe  <= sda_oe_q;
			o_sda_out <= load_q ? drive_q[7] : sda_out_q;
			o_config  <= config_q;
			o_overtemp <= overtemp_q;
			o_hyst    <= hyst_q;
		end
	end

endmodule // tsp_i2c_port
`default_nettype wire

// *** rtl/tsp_params.svh ***
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH

`define TSP_PTR_TEMP       8'h00
`define TSP_PTR_CONFIG     8'h01
`define TSP_PTR_HYST       8'h02
`define TSP_PTR_OVERTEMP   8'h03
`define TSP_RST_TEMP       16'h0000
`define TSP_RST_CONFIG     16'h0040
`define TSP_RST_HYST       16'h4b00
`define TSP_RST_OVERTEMP   16'h5000
`define TSP_ADDR_BASE      4'h9
`define TSP_CFG_FORMAT     7
`define TSP_CFG_RES_HI     6
`define TSP_CFG_RES_LO     5
`define TSP_CFG_TIMEOUT    4
`define TSP_CFG_PEC        3
`define TSP_CLK_MHZ        250
`define TSP_TIMEOUT_MS     30
`define TSP_TIMEOUT_CYC    (`TSP_TIMEOUT_MS * 1000 * `TSP_CLK_MHZ)
`define TSP_CRC_POLY       8'h07

`endif

// *** rtl/tsp_pkg.sv ***
package tsp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK
	} tsp_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} tsp_bus_t;
endpackage

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_mclk = 0;
	logic        i_rstn = 1;
	logic        i_temp_valid = 0;
	logic [2:0]  i_addr_sel = 3'h0;
	logic [15:0] i_temp_raw = 16'h0;
	logic        scl, m_oe, res_stb, dev_oe, dev_out;
	logic [15:0] cfg, hy, ot, v, m;
	logic [7:0]  res, ex, crc;
	logic [31:0] seed = 32'h5c6a;
	logic [7:0]  expq[$];
	int          error_cnt = 0;
	int          n_checks = 0;
	int          cyc = 0;
	wire         sda = !m_oe && !(dev_oe && !dev_out);

	tsp_i2c_port #(.TIMEOUT_CYC(200)) u_tsp_i2c_port (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_scl(scl),
		.i_sda(sda), .i_addr_sel(i_addr_sel), .i_temp_raw(i_temp_raw), .i_temp_valid(i_temp_valid),
		.o_sda_oe(dev_oe), .o_sda_out(dev_out), .o_config(cfg), .o_overtemp(ot), .o_hyst(hy));
	tsp_i2c_master u_tsp_i2c_master (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda), .o_res(res), .o_res_stb(res_stb));

	always #2 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			print_verdict();
		end
	end
	always @(posedge res_stb) begin
		ex = expq.size() > 0 ? expq.pop_front() : 8'hxx;
		n_checks++;
		if (res !== ex) begin
			error_cnt++;
			$display("[FAIL] %0t byte %h expected %h", $time, res, ex);
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c ^= d;
		for (int i = 0; i < 8; i++)
			c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic chk(input logic [15:0] a, input logic [15:0] b);
		n_checks++;
		if (a !== b) begin
			error_cnt++;
			$display("[FAIL] %0t port %h expected %h", $time, a, b);
		end
	endtask
	task automatic xb(input logic [7:0] d, input logic rd, input logic nk, input logic [7:0] e, input int st = 0);
		expq.push_back(e);
		crc = crc8(crc, rd ? e : d);
		u_tsp_i2c_master.xfer(d, rd, nk, st);
	endtask
	task automatic wr_tx(input logic [7:0] p, input logic [15:0] w, input int n, input logic pec = 0);
		crc = 8'h00;
		u_tsp_i2c_master.start();
		xb({4'h9, i_addr_sel, 1'b0}, 0, 0, 8'h00);
		xb(p, 0, 0, 8'h00);
		for (int i = 0; i < n; i++)
			xb(8'((i[1] ? ~w : w) >> (i[0] ? 0 : 8)), 0, 0, 8'h00);
		if (pec)
			xb(crc, 0, 0, 8'h00);
		u_tsp_i2c_master.stop();
	endtask
	task automatic rd_tx(input logic [7:0] p, input logic [15:0] w, input int n, input logic pec = 0);
		crc = 8'h00;
		u_tsp_i2c_master.start();
		xb({4'h9, i_addr_sel, 1'b0}, 0, 0, 8'h00);
		xb(p, 0, 0, 8'h00);
		u_tsp_i2c_master.start();
		xb({4'h9, i_addr_sel, 1'b1}, 0, 0, 8'h00);
		for (int i = 0; i < n; i++)
			xb(8'hff, 1, i == n - 1 && !pec, 8'(w >> (i[0] ? 0 : 8)));
		if (pec)
			xb(8'hff, 1, 1, crc);
		u_tsp_i2c_master.stop();
	endtask
	task automatic reset_dut();
		i_rstn = 0;
		repeat (4) @(posedge i_mclk);
		#1 i_rstn = 1;
		repeat (4) @(posedge i_mclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#1;
		reset_dut();
		for (int p = 2; p < 4; p++) begin
			v = 16'(rnd());
			wr_tx(8'(p), v, 2);
			rd_tx(8'(p), v, 3);
			chk(p == 2 ? hy : ot, v);
		end
		wr_tx(8'h03, ~v, 1);
		rd_tx(8'h03, {~v[15:8], v[7:0]}, 2);
		wr_tx(8'h02, v, 4);
		chk(hy, ~v);
		chk(ot, {~v[15:8], v[7:0]});
		for (int k = 0; k < 8; k++) begin
			v = {8'h00, k[2], k[1:0], 5'h00};
			wr_tx(8'h01, v, 2);
			chk(cfg, v);
			m = ~(16'hffff >> ((k[1:0] == 2'h3 ? 12 : 8 + k[1:0]) + k[2]));
			@(posedge i_mclk) #1;
			i_temp_raw = 16'(rnd());
			i_temp_valid = 1;
			@(posedge i_mclk) #1;
			i_temp_valid = 0;
			wr_tx(8'h00, ~i_temp_raw, 2);
			rd_tx(8'h00, i_temp_raw & m, 2);
		end
		for (int a = 0; a < 8; a++) begin
			@(posedge i_mclk) #1;
			i_addr_sel = 3'(a);
			u_tsp_i2c_master.start();
			xb({4'h9 ^ {3'h0, a[0]}, 3'(a) ^ {2'h0, !a[0]}, 1'b0}, 0, 0, 8'h01);
			u_tsp_i2c_master.stop();
			rd_tx(8'h01, 16'h00e0, 2);
		end
		v = 16'(rnd());
		wr_tx(8'h01, 16'h0008, 2);
		wr_tx(8'h02, v, 2, 1);
		rd_tx(8'h02, v, 2, 1);
		u_tsp_i2c_master.start();
		xb({4'h9, i_addr_sel, 1'b0}, 0, 0, 8'h01, 300);
		u_tsp_i2c_master.stop();
		rd_tx(8'h02, v, 2, 1);
		reset_dut();
		rd_tx(8'h00, 16'h0000, 2);
		rd_tx(8'h01, 16'h0040, 2);
		rd_tx(8'h02, 16'h4b00, 2);
		rd_tx(8'h03, 16'h5000, 2);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire

// *** tb/tsp_i2c_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsp_params.svh"
module tsp_i2c_chk #(
	parameter int unsigned TIMEOUT_CYC = `TSP_TIMEOUT_CYC
) (
	input wire logic        i_mclk,
	input wire logic        i_rstn,
	input wire logic        i_scl,
	input wire logic        i_sda,
	input wire logic [2:0]  i_addr_sel,
	input wire logic [15:0] i_temp_raw,
	input wire logic        i_temp_valid,
	input wire logic        o_sda_oe,
	input wire logic        o_sda_out,
	input wire logic [15:0] o_config,
	input wire logic [15:0] o_overtemp,
	input wire logic [15:0] o_hyst
);
	logic [31:0] hi_q;
	logic [31:0] lo_q;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// Run lengths of the clock line, so timing rules need no long repetitions.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			hi_q <= '0;
			lo_q <= '0;
		end else begin
			hi_q <= i_scl ? hi_q + 32'h1 : 32'h0;
			lo_q <= i_scl ? 32'h0 : lo_q + 32'h1;
		end
	end
	a_reset_values: assert property (disable iff (1'b0) !i_rstn |-> !o_sda_oe
		&& o_config == `TSP_RST_CONFIG && o_hyst == `TSP_RST_HYST && o_overtemp == `TSP_RST_OVERTEMP)
		else $error("reset value wrong");
	a_stable_high: assert property (hi_q >= 32'd6 |-> $stable(o_sda_oe) && (!o_sda_oe || $stable(o_sda_out)))
		else $error("sda drive moved while clock high");
	a_drive_low: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("drive began with clock high");
	a_release_low: assert property ($fell(o_sda_oe) |-> !i_scl) else $error("release with clock high");
	a_drive_len: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8]) else $error("drive too short");
	a_idle_free: assert property (hi_q >= 32'd40 |-> !o_sda_oe) else $error("sda driven while idle");
	a_regs_high: assert property ($changed(o_config) || $changed(o_hyst) || $changed(o_overtemp) |-> i_scl)
		else $error("register moved with clock low");
	a_bus_timeout: assert property (!o_config[4] && lo_q > TIMEOUT_CYC + 32'd16 |-> !o_sda_oe)
		else $error("timeout kept sda driven");
endmodule // tsp_i2c_chk
bind tsp_i2c_port tsp_i2c_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_tsp_i2c_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
	.i_scl(i_scl), .i_sda(i_sda), .i_addr_sel(i_addr_sel), .i_temp_raw(i_temp_raw), .i_temp_valid(i_temp_valid),
	.o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out), .o_config(o_config), .o_overtemp(o_overtemp), .o_hyst(o_hyst));
`default_nettype wire

// *** tb/tsp_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsp_i2c_master (
	output logic       o_scl = 1'b1,
	output logic       o_sda_oe = 1'b0,
	input  wire logic  i_sda,
	output logic [7:0] o_res = 8'h00,
	output logic       o_res_stb = 1'b0
);
	// Only pulls low; a released line rises through the pull-up.
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe = !b;
		#20 o_scl = 1;
		#20 r = i_sda;
		#20 o_scl = 0;
		#20;
	endtask
	// Entered with the clock low this is a repeated start.
	task automatic start();
		o_sda_oe = 0;
		#20 o_scl = 1;
		#20 o_sda_oe = 1;
		#20 o_scl = 0;
		#20;
	endtask
	task automatic stop();
		o_sda_oe = 1;
		#20 o_scl = 1;
		#20 o_sda_oe = 0;
		#40;
	endtask
	task automatic xfer(input logic [7:0] d, input logic rd, input logic nack, input int stall);
		logic [7:0] q;
		logic       a;
		for (int i = 7; i >= 0; i--)
			bit_io(rd | d[i], q[i]);
		#(stall * 4);
		bit_io(rd ? nack : 1'b1, a);
		o_res = rd ? q : {7'h0, a};
		o_res_stb = 1;
		#4 o_res_stb = 0;
	endtask
endmodule // tsp_i2c_master
`default_nettype wire
